// File: lhd_pkg.sv
`default_nettype none
package lhd_pkg;

  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned NUM_SINKS = 6;
  localparam int unsigned DAC_WIDTH = 8;

  // dim pin sampling rate and the divider that gives it
  localparam int unsigned DIM_SAMPLE_HZ = 20_000_000;
  localparam int unsigned DIM_DIV_CYC = CLK_FREQ_HZ / DIM_SAMPLE_HZ;

  // periodic headroom update while dimming sits at full duty
  localparam int unsigned UPDATE_INTERVAL_MS = 10;
  localparam int unsigned UPDATE_INTERVAL_CYC =
    (CLK_FREQ_HZ / 1000) * UPDATE_INTERVAL_MS;

  // leading-edge blanking, a least time: round up
  localparam int unsigned LEB_NS = 100;
  localparam int unsigned LEB_CYC =
    (LEB_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;

  // switching period at the lowest switching frequency
  localparam int unsigned SW_FREQ_HZ = 400_000;
  localparam int unsigned SW_PERIOD_CYC = CLK_FREQ_HZ / SW_FREQ_HZ;

  // soft-start: one dac code every step time
  localparam int unsigned SS_STEP_US = 100;
  localparam int unsigned SS_STEP_CYC =
    (CLK_FREQ_HZ / 1_000_000) * SS_STEP_US;
  localparam logic [7:0] SS_TARGET_CODE = 8'h80;

  // reference dac: code 0 sits at the base, one code per lsb
  localparam int unsigned DAC_LSB_UV = 2500;
  localparam int unsigned DAC_BASE_UV = 612500;
  localparam int unsigned VREF_MIN_UV = 600000;
  localparam int unsigned VREF_MAX_UV = 1250000;
  localparam int unsigned DAC_MIN_RAW = (VREF_MIN_UV <= DAC_BASE_UV) ? 0 :
    (VREF_MIN_UV - DAC_BASE_UV + DAC_LSB_UV - 1) / DAC_LSB_UV;
  localparam int unsigned DAC_MAX_RAW =
    (VREF_MAX_UV - DAC_BASE_UV) / DAC_LSB_UV;
  localparam logic [7:0] DAC_CODE_MIN = DAC_MIN_RAW[7:0];
  localparam logic [7:0] DAC_CODE_MAX =
    (DAC_MAX_RAW > 255) ? 8'hFF : DAC_MAX_RAW[7:0];
  localparam logic [7:0] DAC_RESET_CODE = 8'h00;

  // fail-safe resistor code from the power-up measurement
  localparam int unsigned FS_RES_CODE_WIDTH = 4;
  localparam logic [1:0] FS_CUR_OFF = 2'h0;
  localparam logic [1:0] FS_CUR_25MA = 2'h0;
  localparam logic [1:0] FS_CUR_50MA = 2'h1;
  localparam logic [1:0] FS_CUR_75MA = 2'h2;
  localparam logic [1:0] FS_CUR_100MA = 2'h3;

  typedef enum logic [2:0] {
    LHD_OFF = 3'b001,
    LHD_SOFTSTART = 3'b010,
    LHD_RUN = 3'b100
  } lhd_state_t;

endpackage : lhd_pkg

`default_nettype wire

// File: lhd_sync.sv
`timescale 1ns/10ps
`default_nettype none

module lhd_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule : lhd_sync

`default_nettype wire

// File: lhd_headroom_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module lhd_headroom_ctrl #(
  parameter int unsigned UPDATE_CYC = lhd_pkg::UPDATE_INTERVAL_CYC,
  parameter int unsigned SS_STEP = lhd_pkg::SS_STEP_CYC,
  parameter int unsigned SW_PERIOD = lhd_pkg::SW_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable_pin,
  input wire logic supply_uv_ok,
  input wire logic vcc_uv_ok,
  input wire logic failsafe_force_pin,
  input wire logic [lhd_pkg::FS_RES_CODE_WIDTH-1:0] failsafe_res_code,
  input wire logic dim_pin,
  input wire logic cs_trip,
  input wire logic [lhd_pkg::NUM_SINKS-1:0] sink_below_low,
  input wire logic [lhd_pkg::NUM_SINKS-1:0] sink_above_high,
  input wire logic [lhd_pkg::NUM_SINKS-1:0] sink_enable_cfg,
  input wire logic [lhd_pkg::NUM_SINKS-1:0] sink_duty_cfg,
  input wire logic boost_enable_cfg,
  output logic regulator_enable,
  output logic serial_if_enable,
  output logic switch_gate_drive,
  output logic [lhd_pkg::NUM_SINKS-1:0] sink_drive,
  output logic [lhd_pkg::DAC_WIDTH-1:0] dac_code,
  output logic failsafe_active,
  output logic [1:0] failsafe_current_sel,
  output logic bus_addr_alt,
  output logic softstart_done
);
  import lhd_pkg::*;

  localparam int unsigned UW = $clog2(UPDATE_CYC + 1);
  localparam int unsigned SW = $clog2(SS_STEP + 1);
  localparam int unsigned PW = $clog2(SW_PERIOD + 1);
  localparam int unsigned DW = $clog2(DIM_DIV_CYC + 1);
  localparam int unsigned NS = NUM_SINKS;

  // current select in [2:1], alternate address in [0]
  function automatic logic [2:0] fs_res_decode(
    input logic [FS_RES_CODE_WIDTH-1:0] code
  );
    logic [2:0] res;
    res = {FS_CUR_OFF, 1'b0};
    unique case (code)
      4'h0: res = {FS_CUR_OFF, 1'b0};
      4'h1: res = {FS_CUR_25MA, 1'b0};
      4'h2: res = {FS_CUR_25MA, 1'b1};
      4'h3: res = {FS_CUR_50MA, 1'b0};
      4'h4: res = {FS_CUR_50MA, 1'b1};
      4'h5: res = {FS_CUR_75MA, 1'b0};
      4'h6: res = {FS_CUR_75MA, 1'b1};
      4'h7: res = {FS_CUR_100MA, 1'b0};
      4'h8: res = {FS_CUR_100MA, 1'b1};
      default: res = {FS_CUR_OFF, 1'b0};
    endcase
    return res;
  endfunction : fs_res_decode

  logic en_s, sup_s, vcc_s, fs_s, dim_s, cs_s;
  logic [FS_RES_CODE_WIDTH-1:0] fsc_s;
  logic [NS-1:0] low_s, high_s;

  lhd_sync #(.WIDTH(6 + FS_RES_CODE_WIDTH + 2 * NS)) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in({enable_pin, supply_uv_ok, vcc_uv_ok, failsafe_force_pin,
      dim_pin, cs_trip, failsafe_res_code, sink_below_low, sink_above_high}),
    .sync_out({en_s, sup_s, vcc_s, fs_s, dim_s, cs_s, fsc_s, low_s, high_s})
  );

  lhd_state_t state_reg, state_next;
  logic reg_en_reg, reg_en_next;
  logic sif_en_reg, sif_en_next;
  logic fs_act_reg, fs_act_next;
  logic strap_done_reg, strap_done_next;
  logic [1:0] fs_cur_reg, fs_cur_next;
  logic addr_alt_reg, addr_alt_next;
  logic [NS-1:0] sink_reg, sink_next;
  logic ss_done_reg, ss_done_next;
  logic [DAC_WIDTH-1:0] dac_reg, dac_next;

  logic start_ok;
  assign start_ok = en_s & sup_s & vcc_s;

  // enable, lockout, fail-safe and state control
  always_comb begin
    state_next = state_reg;
    reg_en_next = en_s & sup_s;
    sif_en_next = en_s & sup_s;
    strap_done_next = strap_done_reg;
    fs_cur_next = fs_cur_reg;
    addr_alt_next = addr_alt_reg;
    // resistor read once at power-up; later changes have no effect
    if (start_ok && !strap_done_reg) begin
      strap_done_next = 1'b1;
      {fs_cur_next, addr_alt_next} = fs_res_decode(fsc_s);
    end
    fs_act_next = start_ok & fs_s;
    unique case (state_reg)
      LHD_OFF: begin
        if (start_ok) begin
          state_next = LHD_SOFTSTART;
        end
      end
      LHD_SOFTSTART: begin
        if (!start_ok) begin
          state_next = LHD_OFF;
        end else if (dac_reg >= SS_TARGET_CODE) begin
          state_next = LHD_RUN;
        end
      end
      LHD_RUN: begin
        if (!start_ok) begin
          state_next = LHD_OFF;
        end
      end
      default: state_next = LHD_OFF;
    endcase
    ss_done_next = (state_next == LHD_RUN);
    if (state_next == LHD_OFF) begin
      sink_next = '0;
    end else if (start_ok && fs_s) begin
      sink_next = '1;
    end else begin
      sink_next = sink_enable_cfg & sink_duty_cfg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= LHD_OFF;
      reg_en_reg <= 1'b0;
      sif_en_reg <= 1'b0;
      fs_act_reg <= 1'b0;
      strap_done_reg <= 1'b0;
      fs_cur_reg <= FS_CUR_OFF;
      addr_alt_reg <= 1'b0;
      sink_reg <= '0;
      ss_done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      reg_en_reg <= reg_en_next;
      sif_en_reg <= sif_en_next;
      fs_act_reg <= fs_act_next;
      strap_done_reg <= strap_done_next;
      fs_cur_reg <= fs_cur_next;
      addr_alt_reg <= addr_alt_next;
      sink_reg <= sink_next;
      ss_done_reg <= ss_done_next;
    end
  end

  // dim sampling and update tick
  logic [DW-1:0] div_reg, div_next;
  logic dim_smp_reg, dim_smp_next;
  logic dim_prev_reg, dim_prev_next;
  logic [UW-1:0] ivl_reg, ivl_next;
  logic tick_reg, tick_next;

  always_comb begin
    div_next = div_reg;
    dim_smp_next = dim_smp_reg;
    dim_prev_next = dim_prev_reg;
    ivl_next = ivl_reg;
    tick_next = 1'b0;
    if (div_reg == DW'(DIM_DIV_CYC - 1)) begin
      div_next = '0;
      dim_smp_next = dim_s;
      dim_prev_next = dim_smp_reg;
    end else begin
      div_next = div_reg + DW'(1);
    end
    if (dim_prev_reg && !dim_smp_reg && div_reg == '0) begin
      tick_next = 1'b1;
      ivl_next = '0;
    end else if (!dim_smp_reg) begin
      ivl_next = '0;
    end else if (ivl_reg == UW'(UPDATE_CYC - 1)) begin
      tick_next = 1'b1;
      ivl_next = '0;
    end else begin
      ivl_next = ivl_reg + UW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_reg <= '0;
      dim_smp_reg <= 1'b0;
      dim_prev_reg <= 1'b0;
      ivl_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      dim_smp_reg <= dim_smp_next;
      dim_prev_reg <= dim_prev_next;
      ivl_reg <= ivl_next;
      tick_reg <= tick_next;
    end
  end

  // headroom counter, which is the dac code itself
  logic [SW-1:0] ss_cnt_reg, ss_cnt_next;
  logic any_low, all_high;

  always_comb begin
    // disabled sinks neither ask for more nor block a step down
    any_low = |(low_s & sink_enable_cfg);
    all_high = (|sink_enable_cfg) &&
      ((high_s & sink_enable_cfg) == sink_enable_cfg);
    dac_next = dac_reg;
    ss_cnt_next = '0;
    unique case (state_reg)
      LHD_OFF: dac_next = DAC_RESET_CODE;
      LHD_SOFTSTART: begin
        if (ss_cnt_reg == SW'(SS_STEP - 1)) begin
          dac_next = dac_reg + 8'h01;
        end else begin
          ss_cnt_next = ss_cnt_reg + SW'(1);
        end
      end
      LHD_RUN: begin
        if (tick_reg && any_low && dac_reg < DAC_CODE_MAX) begin
          dac_next = dac_reg + 8'h01;
        end else if (tick_reg && !any_low && all_high &&
            dac_reg > DAC_CODE_MIN) begin
          dac_next = dac_reg - 8'h01;
        end
        // one code is one lsb of the reference
        if (dac_next < DAC_CODE_MIN) begin
          dac_next = DAC_CODE_MIN;
        end else if (dac_next > DAC_CODE_MAX) begin
          dac_next = DAC_CODE_MAX;
        end
      end
      default: dac_next = DAC_RESET_CODE;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dac_reg <= DAC_RESET_CODE;
      ss_cnt_reg <= '0;
    end else begin
      dac_reg <= dac_next;
      ss_cnt_reg <= ss_cnt_next;
    end
  end

  // switching cycle and gate drive
  logic [PW-1:0] per_reg, per_next;
  logic gate_reg, gate_next;
  logic conv_run;

  // fail-safe runs the converter whatever the configuration says
  assign conv_run = (state_reg != LHD_OFF) &&
    (fs_act_reg || boost_enable_cfg);

  always_comb begin
    per_next = '0;
    gate_next = 1'b0;
    if (conv_run) begin
      if (per_reg == PW'(SW_PERIOD - 1)) begin
        per_next = '0;
      end else begin
        per_next = per_reg + PW'(1);
      end
      if (per_next == '0) begin
        gate_next = 1'b1;
      end else if (gate_reg && per_reg >= PW'(LEB_CYC) && cs_s) begin
        gate_next = 1'b0;
      end else begin
        gate_next = gate_reg;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      per_reg <= '0;
      gate_reg <= 1'b0;
    end else begin
      per_reg <= per_next;
      gate_reg <= gate_next;
    end
  end

  assign regulator_enable = reg_en_reg;
  assign serial_if_enable = sif_en_reg;
  assign switch_gate_drive = gate_reg;
  assign sink_drive = sink_reg;
  assign dac_code = dac_reg;
  assign failsafe_active = fs_act_reg;
  assign failsafe_current_sel = fs_cur_reg;
  assign bus_addr_alt = addr_alt_reg;
  assign softstart_done = ss_done_reg;

endmodule : lhd_headroom_ctrl

`default_nettype wire

// File: lhd_headroom_ctrl_props.sv
`timescale 1ns/10ps
`default_nettype none
module lhd_headroom_ctrl_props #(
  parameter int unsigned SW_PERIOD = lhd_pkg::SW_PERIOD_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable_pin,
  input wire logic supply_uv_ok,
  input wire logic vcc_uv_ok,
  input wire logic cs_trip,
  input wire logic boost_enable_cfg,
  input wire logic regulator_enable,
  input wire logic serial_if_enable,
  input wire logic switch_gate_drive,
  input wire logic [lhd_pkg::NUM_SINKS-1:0] sink_drive,
  input wire logic [lhd_pkg::DAC_WIDTH-1:0] dac_code,
  input wire logic failsafe_active,
  input wire logic softstart_done
);
  logic [2:0] since_reg;
  logic [7:0] low_cnt_reg;
  logic run_ok;
  // sync pipeline holds reset values for a few edges after release
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) since_reg <= 3'h0;
    else if (since_reg != 3'h7) since_reg <= since_reg + 3'h1;
  end
  assign run_ok = softstart_done && boost_enable_cfg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) low_cnt_reg <= 8'h00;
    else if (switch_gate_drive || !run_ok) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= low_cnt_reg + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_reg_enable: assert property (since_reg == 3'h7 |->
    regulator_enable == $past(enable_pin && supply_uv_ok, 3))
    else $error("regulator enable wrong");
  a_serial_enable: assert property (since_reg == 3'h7 |->
    serial_if_enable == $past(enable_pin && supply_uv_ok, 3))
    else $error("serial enable wrong");
  a_failsafe_full: assert property (failsafe_active |->
    sink_drive == 6'h3F)
    else $error("fail-safe sinks not full");
  a_start_gated: assert property ($changed(dac_code) &&
    !softstart_done |-> $past(enable_pin && supply_uv_ok && vcc_uv_ok, 4))
    else $error("ramp without start");
  a_gate_blank: assert property ($rose(switch_gate_drive) |=>
    (switch_gate_drive || !regulator_enable || !boost_enable_cfg)[*8])
    else $error("gate cut inside blanking");
  a_gate_cs_off: assert property ($rose(switch_gate_drive) ##1
    (cs_trip && switch_gate_drive)[*4] |-> ##[1:10] !switch_gate_drive)
    else $error("gate ignores current sense");
  a_gate_restart: assert property (low_cnt_reg <= SW_PERIOD)
    else $error("no new switching cycle");
  a_dac_step: assert property ($changed(dac_code) && regulator_enable
    && $past(regulator_enable) |-> dac_code == $past(dac_code) + 8'h01
    || (softstart_done && dac_code == $past(dac_code) - 8'h01))
    else $error("dac step not one code");
endmodule : lhd_headroom_ctrl_props
bind lhd_headroom_ctrl lhd_headroom_ctrl_props #(.SW_PERIOD(SW_PERIOD))
  lhd_headroom_ctrl_props_inst (.core_clk, .rst, .enable_pin,
  .supply_uv_ok, .vcc_uv_ok, .cs_trip, .boost_enable_cfg,
  .regulator_enable, .serial_if_enable, .switch_gate_drive, .sink_drive,
  .dac_code, .failsafe_active, .softstart_done);
`default_nettype wire

// File: lhd_stage.sv
`timescale 1ns/10ps
`default_nettype none
module lhd_stage (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic gate,
  input wire logic [4:0] ramp_cyc,
  output logic cs_trip
);
  logic [4:0] cnt_reg;
  // sense ramps only while the switch conducts; zero ramp mimics
  // turn-on spike that blanking has to hide
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) cnt_reg <= 5'h00;
    else if (!gate) cnt_reg <= 5'h00;
    else if (cnt_reg != 5'h1F) cnt_reg <= cnt_reg + 5'h01;
  end
  assign cs_trip = gate && (cnt_reg >= ramp_cyc);
endmodule : lhd_stage
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lhd_pkg::*;
  localparam int UPD = 50;
  logic core_clk = 0, rst = 1, en = 0, sup = 0, vcc = 0, fs = 0, dim = 0;
  logic boost = 1, cs, gate, regen, seren, fsa, alt, done;
  logic [3:0] fcode = 0;
  logic [5:0] lo = 0, hi = 0, m = 6'h3F, duty = 0, sinks;
  logic [7:0] dac, exp;
  logic [1:0] cur;
  logic [4:0] ramp = 5'h03;
  int errors = 0, n_checks = 0;
  always #5 core_clk = ~core_clk;
  lhd_headroom_ctrl #(.UPDATE_CYC(UPD), .SS_STEP(4), .SW_PERIOD(40))
    lhd_headroom_ctrl_inst (.core_clk(core_clk), .rst(rst),
    .enable_pin(en), .supply_uv_ok(sup), .vcc_uv_ok(vcc),
    .failsafe_force_pin(fs), .failsafe_res_code(fcode), .dim_pin(dim),
    .cs_trip(cs), .sink_below_low(lo), .sink_above_high(hi),
    .sink_enable_cfg(m), .sink_duty_cfg(duty), .boost_enable_cfg(boost),
    .regulator_enable(regen), .serial_if_enable(seren),
    .switch_gate_drive(gate), .sink_drive(sinks), .dac_code(dac),
    .failsafe_active(fsa), .failsafe_current_sel(cur),
    .bus_addr_alt(alt), .softstart_done(done));
  lhd_stage lhd_stage_inst (.core_clk(core_clk), .rst(rst), .gate(gate),
    .ramp_cyc(ramp), .cs_trip(cs));
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    n_checks++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask : chk
  task automatic conclude;
    if (errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // resistor index 1..8 in table order; others fall back to off
  function automatic logic [7:0] fexp(input int i);
    if (i < 1 || i > 8) return 8'h00;
    return {5'h00, 2'((i - 1) / 2), 1'(i % 2 == 0)};
  endfunction : fexp
  function automatic logic [7:0] nxt(input logic [7:0] c,
    input logic [5:0] k, input logic [5:0] l, input logic [5:0] h);
    if ((l & k) != 6'h00) return (c == DAC_CODE_MAX) ? c : c + 8'h01;
    if (k != 6'h00 && (h & k) == k)
      return (c == DAC_CODE_MIN) ? c : c - 8'h01;
    return c;
  endfunction : nxt
  initial begin
    void'($urandom(32'h3C8E46DA));
    for (int i = 0; i < 10; i++) begin
      rst = 1;
      en = 0;
      vcc = 0;
      fcode = 4'(i);
      cyc(20);
      rst = 0;
      en = 1;
      sup = 1;
      cyc(20);
      chk(8'(regen), 8'h01);
      chk(dac, 8'h00);
      vcc = 1;
      cyc(20);
      chk({5'h00, cur, alt}, fexp(i));
      fcode = 4'($urandom);
      cyc(10);
      chk({5'h00, cur, alt}, fexp(i));
    end
    for (int k = 0; k < 2000 && done !== 1'b1; k++) cyc(1);
    chk(dac, SS_TARGET_CODE);
    exp = SS_TARGET_CODE;
    repeat (24) begin
      m = 6'($urandom);
      lo = 6'($urandom & $urandom & $urandom);
      hi = 6'($urandom);
      ramp = 5'($urandom);
      duty = 6'($urandom);
      if ($urandom % 3 == 0) begin
        lo = 6'h00;
        hi = 6'h3F;
      end
      cyc(10);
      dim = 1;
      cyc(10);
      dim = 0;
      exp = nxt(exp, m, lo, hi);
      cyc(15);
      chk(dac, exp);
      chk(8'(sinks), 8'(m & duty));
    end
    // prompt trip exercises blanking during the long ramps
    ramp = 5'h00;
    m = 6'h3F;
    lo = 6'h3F;
    hi = 6'h00;
    dim = 1;
    // enough ticks to reach the top even from the lowest random start
    cyc(200 * UPD);
    chk(dac, DAC_CODE_MAX);
    dim = 0;
    cyc(10);
    lo = 6'h00;
    hi = 6'h3F;
    cyc(10);
    dim = 1;
    cyc(25 + 10 * UPD);
    chk(dac, DAC_CODE_MAX - 8'h0A);
    cyc(300 * UPD);
    chk(dac, DAC_CODE_MIN);
    dim = 0;
    boost = 0;
    fs = 1;
    cyc(10);
    chk(8'(sinks), 8'h3F);
    chk(8'(fsa), 8'h01);
    for (int k = 0; k < 45 && gate !== 1'b1; k++) cyc(1);
    chk(8'(gate), 8'h01);
    fs = 0;
    boost = 1;
    en = 0;
    cyc(10);
    chk({6'h00, regen, seren}, 8'h00);
    conclude();
  end
  // whole run is about 28k cycles
  initial begin
    repeat (60000) @(posedge core_clk);
    errors++;
    conclude();
  end
endmodule : tb
`default_nettype wire
